// File: rtl/pieabc_top.sv
// APB register block holding the port A, B and C input gates and their gated inputs.
//
// How it works
// [RULE1] Port A gate register at index 30B8h.
// [RULE2] Port A bit 4 reserved, reads zero.
// [RULE3] Port B gate register at index 30B9h.
// [RULE4] Port C gate register at index 30BAh.
// [RULE5] Implemented bits read back last written value.
// [RULE6] Enable one passes pin level inward.
// [RULE7] Enable zero blocks pin from input data.
// [RULE8] Reset clears every gate bit to zero.
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module pieabc_top #(
    parameter int PADDR_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] port_a_pin,
    input wire logic [7:0] port_b_pin,
    input wire logic [7:0] port_c_pin,
    output logic [7:0] port_a_in_data,
    output logic [7:0] port_b_in_data,
    output logic [7:0] port_c_in_data,
    output logic [7:0] port_a_pin_input_gate_bits,
    output logic [7:0] port_b_pin_input_gate_bits,
    output logic [7:0] port_c_pin_input_gate_bits
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------

    // The map needs a 16-bit byte address; a narrower bus cannot reach it.
    if (PADDR_W < pieabc_pkg::MAP_ADDR_W) begin : g_bad_addr
        $error("pieabc_top needs PADDR_W of at least 16");
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    // Decode used both by the read capture and by the write strobe.
    // Upper address bits beyond the map must be zero, so aliases never hit.
    function automatic pieabc_pkg::pieabc_sel_e decode_addr(input logic [PADDR_W-1:0] addr);
        logic [PADDR_W-1:0] a_hit;
        logic [PADDR_W-1:0] b_hit;
        logic [PADDR_W-1:0] c_hit;
        a_hit = PADDR_W'(pieabc_pkg::ADDR_PORT_A_INPUT_GATE);
        b_hit = PADDR_W'(pieabc_pkg::ADDR_PORT_B_INPUT_GATE);
        c_hit = PADDR_W'(pieabc_pkg::ADDR_PORT_C_INPUT_GATE);
        if (addr == a_hit) begin
            return pieabc_pkg::PIEABC_SEL_A;
        end else if (addr == b_hit) begin
            return pieabc_pkg::PIEABC_SEL_B;
        end else if (addr == c_hit) begin
            return pieabc_pkg::PIEABC_SEL_C;
        end else begin
            return pieabc_pkg::PIEABC_SEL_NONE;
        end
    endfunction

    pieabc_pkg::pieabc_sel_e sel; // Register addressed by the current transfer.
    logic setup_phase; // First cycle of a transfer.
    logic access_phase; // Second cycle, where the transfer completes.
    logic wr_lane0; // Write that carries the low byte.

    always_comb begin
        sel = decode_addr(paddr);
        setup_phase = psel && !penable;
        access_phase = psel && penable;
        wr_lane0 = access_phase && pwrite && pstrb[0];
    end

    // ------------------------------------------------------------------
    // Gate registers
    // ------------------------------------------------------------------

    logic [7:0] gate_a_d; // Next port A gate bits.
    logic [7:0] gate_a_q; // Port A gate bits.
    logic [7:0] gate_b_d; // Next port B gate bits.
    logic [7:0] gate_b_q; // Port B gate bits.
    logic [7:0] gate_c_d; // Next port C gate bits.
    logic [7:0] gate_c_q; // Port C gate bits.

    // A write lands only at the completing access edge; a cleared low strobe
    // leaves the byte alone, since the upper lanes carry nothing here.
    always_comb begin
        gate_a_d = gate_a_q;
        gate_b_d = gate_b_q;
        gate_c_d = gate_c_q;
        if (wr_lane0) begin
            unique case (sel)
                // [RULE1] Port A write.
                // [RULE2] Reserved bit masked.
                pieabc_pkg::PIEABC_SEL_A: begin
                    gate_a_d = pwdata[7:0] & pieabc_pkg::PORT_A_MASK;
                end
                // [RULE3] Port B write.
                pieabc_pkg::PIEABC_SEL_B: begin
                    gate_b_d = pwdata[7:0] & pieabc_pkg::PORT_B_MASK;
                end
                // [RULE4] Port C write.
                pieabc_pkg::PIEABC_SEL_C: begin
                    gate_c_d = pwdata[7:0] & pieabc_pkg::PORT_C_MASK;
                end
                // Unmapped writes change nothing.
                pieabc_pkg::PIEABC_SEL_NONE: begin
                    gate_a_d = gate_a_q;
                end
            endcase
        end
    end

    // [RULE8] Reset clears gates.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_a_q <= pieabc_pkg::GATE_RESET;
            gate_b_q <= pieabc_pkg::GATE_RESET;
            gate_c_q <= pieabc_pkg::GATE_RESET;
        end else begin
            gate_a_q <= gate_a_d;
            gate_b_q <= gate_b_d;
            gate_c_q <= gate_c_d;
        end
    end

    // ------------------------------------------------------------------
    // Read data and bus answer
    // ------------------------------------------------------------------

    logic [31:0] rdata_d; // Read word captured in the setup cycle.
    logic [31:0] rdata_q; // Read word presented during the access cycle.

    // The word is captured at the end of setup so prdata comes from a flop
    // and the slave can still answer with no wait state. A write can never
    // coincide with a read setup, so the captured value is current.
    always_comb begin
        rdata_d = rdata_q;
        if (setup_phase && !pwrite) begin
            // [RULE5] Readback of written bits.
            unique case (sel)
                pieabc_pkg::PIEABC_SEL_A: begin
                    rdata_d = {24'h00_0000, gate_a_q};
                end
                pieabc_pkg::PIEABC_SEL_B: begin
                    rdata_d = {24'h00_0000, gate_b_q};
                end
                pieabc_pkg::PIEABC_SEL_C: begin
                    rdata_d = {24'h00_0000, gate_c_q};
                end
                pieabc_pkg::PIEABC_SEL_NONE: begin
                    rdata_d = pieabc_pkg::RDATA_IDLE;
                end
            endcase
        end
    end

    // Read word register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= pieabc_pkg::RDATA_IDLE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Every transfer completes in its first access cycle; unmapped addresses
    // answer with an error so software notices a bad pointer.
    always_comb begin
        pready = 1'b1;
        pslverr = access_phase && (sel == pieabc_pkg::PIEABC_SEL_NONE);
    end

    assign prdata = rdata_q;
    assign port_a_pin_input_gate_bits = gate_a_q;
    assign port_b_pin_input_gate_bits = gate_b_q;
    assign port_c_pin_input_gate_bits = gate_c_q;

    // ------------------------------------------------------------------
    // Input gates
    // ------------------------------------------------------------------

    // [RULE6] Enabled pins pass.
    // [RULE7] Disabled pins blocked.
    pieabc_gate #(
        .WIDTH(pieabc_pkg::PORT_W)
    ) u_gate_a (
        .pclk(pclk),
        .presetn(presetn),
        .pin_level(port_a_pin),
        .gate_enable(gate_a_q),
        .gated_level(port_a_in_data)
    );

    // Port B gate, all eight pins implemented.
    pieabc_gate #(
        .WIDTH(pieabc_pkg::PORT_W)
    ) u_gate_b (
        .pclk(pclk),
        .presetn(presetn),
        .pin_level(port_b_pin),
        .gate_enable(gate_b_q),
        .gated_level(port_b_in_data)
    );

    // Port C gate, all eight pins implemented.
    pieabc_gate #(
        .WIDTH(pieabc_pkg::PORT_W)
    ) u_gate_c (
        .pclk(pclk),
        .presetn(presetn),
        .pin_level(port_c_pin),
        .gate_enable(gate_c_q),
        .gated_level(port_c_in_data)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    // Port A takes the masked low byte of a completed write.
    a_port_a_write: assert property ( // [RULE1]
        @(posedge pclk) disable iff (!presetn)
        (wr_lane0 && sel == pieabc_pkg::PIEABC_SEL_A)
        |=> (gate_a_q == ($past(pwdata[7:0]) & pieabc_pkg::PORT_A_MASK))
    ) else $error("Port A gate did not take the written byte.");

    // The reserved port A bit never shows in the register or the read word.
    a_rsvd_bit_zero: assert property ( // [RULE2]
        @(posedge pclk) disable iff (!presetn)
        !gate_a_q[pieabc_pkg::PORT_A_RSVD_BIT]
        && !($past(setup_phase && !pwrite && sel == pieabc_pkg::PIEABC_SEL_A)
        && prdata[pieabc_pkg::PORT_A_RSVD_BIT])
    ) else $error("Reserved port A bit is not zero.");

    // Port B takes the full low byte of a completed write.
    a_port_b_write: assert property ( // [RULE3]
        @(posedge pclk) disable iff (!presetn)
        (wr_lane0 && sel == pieabc_pkg::PIEABC_SEL_B)
        |=> (gate_b_q == $past(pwdata[7:0]))
    ) else $error("Port B gate did not take the written byte.");

    // Port C takes the full low byte of a completed write.
    a_port_c_write: assert property ( // [RULE4]
        @(posedge pclk) disable iff (!presetn)
        (wr_lane0 && sel == pieabc_pkg::PIEABC_SEL_C)
        |=> (gate_c_q == $past(pwdata[7:0]))
    ) else $error("Port C gate did not take the written byte.");

    // A read of port B returns the gate bits as they stood at setup.
    a_read_back_b: assert property ( // [RULE5]
        @(posedge pclk) disable iff (!presetn)
        (setup_phase && !pwrite && sel == pieabc_pkg::PIEABC_SEL_B)
        |=> (prdata == {24'h00_0000, $past(gate_b_q)})
    ) else $error("Port B read did not return the gate bits.");

    // An enabled port C pin 0 reaches the input data one edge later.
    a_pass_enabled: assert property ( // [RULE6]
        @(posedge pclk) disable iff (!presetn)
        gate_c_q[0] |=> (port_c_in_data[0] == $past(port_c_pin[0]))
    ) else $error("Enabled port C pin did not pass.");

    // The top pin of port A is checked too, so a swapped gate shows up.
    a_pass_port_a: assert property ( // [RULE6]
        @(posedge pclk) disable iff (!presetn)
        gate_a_q[7] |=> (port_a_in_data[7] == $past(port_a_pin[7]))
    ) else $error("Enabled port A pin did not pass.");

    // A closed gate never lets a high level through on any port.
    a_block_disabled: assert property ( // [RULE7]
        @(posedge pclk) disable iff (!presetn)
        ((port_a_in_data & ~$past(gate_a_q)) == 8'h00)
        && ((port_b_in_data & ~$past(gate_b_q)) == 8'h00)
        && ((port_c_in_data & ~$past(gate_c_q)) == 8'h00)
    ) else $error("Disabled pin reached the input data.");

    // At the first edge after reset release every gate is still closed.
    a_reset_clear: assert property ( // [RULE8]
        @(posedge pclk)
        (presetn && !$past(presetn))
        |-> (gate_a_q == pieabc_pkg::GATE_RESET
            && gate_b_q == pieabc_pkg::GATE_RESET
            && gate_c_q == pieabc_pkg::GATE_RESET)
    ) else $error("Gate bits not clear after reset.");

    // An unmapped access errors and leaves all gate bits unchanged.
    a_unmapped_quiet: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_phase && sel == pieabc_pkg::PIEABC_SEL_NONE)
        |-> pslverr ##1 ($stable(gate_a_q) && $stable(gate_b_q) && $stable(gate_c_q))
    ) else $error("Unmapped access misbehaved.");

    // A mapped access never answers with an error, or drivers would retry forever.
    a_mapped_no_err: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access_phase && sel != pieabc_pkg::PIEABC_SEL_NONE) |-> !pslverr
    ) else $error("Mapped access answered with an error.");

endmodule
`default_nettype wire

// File: rtl/pieabc_pkg.sv
// Package of register indices, addresses, masks and reset values for the input gates.
package pieabc_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------

    // Width of the byte address that the register map needs.
    localparam int MAP_ADDR_W = 16;

    // Register indices as printed; the byte address is four times the index.
    localparam logic [15:0] IDX_PORT_A_INPUT_GATE = 16'h30b8;
    localparam logic [15:0] IDX_PORT_B_INPUT_GATE = 16'h30b9;
    localparam logic [15:0] IDX_PORT_C_INPUT_GATE = 16'h30ba;

    // Byte addresses, one aligned 32-bit word per register.
    localparam logic [15:0] ADDR_PORT_A_INPUT_GATE = {IDX_PORT_A_INPUT_GATE[13:0], 2'b00};
    localparam logic [15:0] ADDR_PORT_B_INPUT_GATE = {IDX_PORT_B_INPUT_GATE[13:0], 2'b00};
    localparam logic [15:0] ADDR_PORT_C_INPUT_GATE = {IDX_PORT_C_INPUT_GATE[13:0], 2'b00};

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------

    // Every port register is eight bits wide, in the low byte of the word.
    localparam int PORT_W = 8;

    // Port A bit 4 is reserved and must always read zero.
    localparam int PORT_A_RSVD_BIT = 4;

    // Implemented-bit masks per port.
    localparam logic [7:0] PORT_A_MASK = 8'hef;
    localparam logic [7:0] PORT_B_MASK = 8'hff;
    localparam logic [7:0] PORT_C_MASK = 8'hff;

    // All gates come up closed.
    localparam logic [7:0] GATE_RESET = 8'h00;

    // Read data returned for reserved bits and for unmapped addresses.
    localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

    // Register selected by a bus address.
    typedef enum logic [1:0] {
        PIEABC_SEL_NONE,
        PIEABC_SEL_A,
        PIEABC_SEL_B,
        PIEABC_SEL_C
    } pieabc_sel_e;

endpackage

// File: rtl/pieabc_gate.sv
// Per-port input gate: registers each pin level only where its enable is set.
`timescale 1ns/1ps
`default_nettype none

module pieabc_gate #(
    parameter int WIDTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] pin_level,
    input wire logic [WIDTH-1:0] gate_enable,
    output logic [WIDTH-1:0] gated_level
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------

    // A zero-width port has nothing to gate.
    if (WIDTH < 1) begin : g_bad_width
        $error("pieabc_gate needs WIDTH of at least one");
    end

    // ------------------------------------------------------------------
    // Gate and capture
    // ------------------------------------------------------------------

    logic [WIDTH-1:0] gated_d; // Next captured level.
    logic [WIDTH-1:0] gated_q; // Captured level seen by the port input path.

    // Closed gates force zero so a floating pin never toggles the logic behind.
    always_comb begin
        gated_d = pin_level & gate_enable;
    end

    // The capture register holds zero through reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gated_q <= '0;
        end else begin
            gated_q <= gated_d;
        end
    end

    assign gated_level = gated_q;

endmodule
`default_nettype wire

// File: sim/pieabc_pin_model.sv
// Far-side model of the port A, B and C pins, moving every cycle.
`timescale 1ns/1ps
`default_nettype none

module pieabc_pin_model (
    input wire logic pclk,
    input wire logic presetn,
    output logic [7:0] port_a_pin,
    output logic [7:0] port_b_pin,
    output logic [7:0] port_c_pin
);
    // Step counter that sets the pin pattern.
    logic [7:0] step_q;

    // ------------------------------------------------------------------
    // Pin pattern
    // ------------------------------------------------------------------
    // Pins change on every cycle, so a stuck or stale input path shows at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_q <= 8'h00;
        end else begin
            step_q <= step_q + 8'h01;
        end
    end

    // Only port A carries the fast bit in both nibbles; ports B and C carry it in the high nibble only. Every pin position is exercised.
    assign port_a_pin = {step_q[3:0], ~step_q[3:0]};
    assign port_b_pin = {step_q[2:0], step_q[7:3]} ^ 8'ha5;
    assign port_c_pin = ~{step_q[0], step_q[1], step_q[2], step_q[3], step_q[4:1]};
endmodule

`default_nettype wire

// File: sim/tb.sv
// Self-checking testbench for the port input gate register block.
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [7:0] a_pin, b_pin, c_pin, a_in, b_in, c_in, a_gate, b_gate, c_gate;
    int miscompares = 0;
    int samples_checked = 0;
    // Gate values the bench expects, one per port A, B, C.
    logic [7:0] gate_exp [3];
    logic [15:0] addr_tab [3] = '{pieabc_pkg::ADDR_PORT_A_INPUT_GATE,
        pieabc_pkg::ADDR_PORT_B_INPUT_GATE, pieabc_pkg::ADDR_PORT_C_INPUT_GATE};
    logic [7:0] mask_tab [3] = '{pieabc_pkg::PORT_A_MASK, pieabc_pkg::PORT_B_MASK,
        pieabc_pkg::PORT_C_MASK};

    pieabc_top #(.PADDR_W(16)) u_pieabc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_a_pin(a_pin),
        .port_b_pin(b_pin), .port_c_pin(c_pin), .port_a_in_data(a_in),
        .port_b_in_data(b_in), .port_c_in_data(c_in), .port_a_pin_input_gate_bits(a_gate),
        .port_b_pin_input_gate_bits(b_gate), .port_c_pin_input_gate_bits(c_gate));

    pieabc_pin_model u_pieabc_pin_model (.pclk(pclk), .presetn(presetn),
        .port_a_pin(a_pin), .port_b_pin(b_pin), .port_c_pin(c_pin));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    // Counts every comparison; a mismatch is reported at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high at an edge.
    task automatic apb(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // The watchdog cuts this short should pready never come.
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write of one gate byte; the upper lanes carry ones that must be ignored.
    task automatic wr(input logic [15:0] addr, input logic [7:0] val);
        logic [31:0] d;
        logic e;
        apb(1'b1, addr, {24'hffffff, val}, d, e);
    endtask

    // Reads a word and compares both the data and the error response.
    task automatic rd(input logic [15:0] addr, input logic [31:0] exp, input logic exp_err);
        logic [31:0] d;
        logic e;
        apb(1'b0, addr, 32'h0, d, e);
        check(d, exp);
        check({31'h0, e}, {31'h0, exp_err});
    endtask

    // Compares gated inputs each cycle against the last-cycle pins and the known gates.
    task automatic watch_pins(input int cycles);
        logic [23:0] exp;
        repeat (cycles) begin
            @(posedge pclk);
            exp = {a_pin & gate_exp[0], b_pin & gate_exp[1], c_pin & gate_exp[2]};
            #1;
            check({8'h0, a_in, b_in, c_in}, {8'h0, exp});
        end
    endtask

    // Writes all three gates and keeps the masked values the bench expects.
    task automatic set_gates(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        logic [7:0] v [3];
        v = '{a, b, c};
        for (int i = 0; i < 3; i++) begin
            wr(addr_tab[i], v[i]);
            gate_exp[i] = v[i] & mask_tab[i];
        end
    endtask

    // Reads all three registers back and checks the exported gate bits as well.
    task automatic read_all();
        for (int i = 0; i < 3; i++) begin
            rd(addr_tab[i], {24'h0, gate_exp[i]}, 1'b0);
        end
        check({8'h0, a_gate, b_gate, c_gate},
              {8'h0, gate_exp[0], gate_exp[1], gate_exp[2]});
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Straight after the first reset every gate reads back closed.
    task automatic sc_after_reset();
        read_all();
    endtask

    // Patterns per port, written back to back and read back; port A bit 4 stays zero.
    task automatic sc_readback();
        logic [7:0] pats [5] = '{8'hff, 8'h00, 8'ha5, 8'h5a, 8'h10};
        foreach (pats[p]) begin
            set_gates(pats[p], ~pats[p], pats[p] ^ 8'h3c);
            read_all();
        end
    endtask

    // Unmapped address errors without side effects; a write without the low-lane strobe is ignored.
    task automatic sc_refuse();
        wr(pieabc_pkg::ADDR_PORT_C_INPUT_GATE + 16'h0004, 8'hff);
        rd(pieabc_pkg::ADDR_PORT_C_INPUT_GATE + 16'h0004, 32'h0, 1'b1);
        pstrb <= 4'he;
        wr(addr_tab[1], 8'h77);
        pstrb <= 4'hf;
        read_all();
    endtask

    // Pins flow in only where enabled, across gate changes.
    task automatic sc_gating();
        set_gates(8'h3c, 8'h0f, 8'hf0);
        watch_pins(12);
        set_gates(8'hff, 8'hff, 8'hff);
        watch_pins(12);
        set_gates(8'h00, 8'h00, 8'h00);
        watch_pins(12);
    endtask

    // A reset in mid-run closes every gate again.
    task automatic sc_reset_mid();
        set_gates(8'hff, 8'hff, 8'hff);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        gate_exp = '{8'h00, 8'h00, 8'h00};
        read_all();
        watch_pins(4);
    endtask

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    // Prints the verdict once and ends the run; the watchdog lands here too.
    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Free-running bus clock, 100 ns period.
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // The whole run takes well under a thousand cycles; this limit only catches a hang.
    initial begin
        repeat (5000) @(posedge pclk);
        miscompares++;
        conclude();
    end

    // Holds reset for four edges, then runs every scenario in turn.
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        gate_exp = '{8'h00, 8'h00, 8'h00};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        sc_after_reset();
        sc_readback();
        sc_refuse();
        sc_gating();
        sc_reset_mid();
        conclude();
    end
endmodule

`default_nettype wire
